/* wtt_top.sv */
// Purpose: Watchpoint comparator control that raises trace start and stop triggers.
// Assumes: Bus observer and comparator hits come from logic on mclk_in; no synchroniser needed.
// Notes:   Registers sit on a plain strobe port; read data appear one cycle after the strobe.
`timescale 1ns/1ps
// Operation
// - Comparator 1 function register reads zero and ignores writes on data-value bits.
// - Comparator 1 match flag sets on match, holds, and clears when read.
// - Selector 0000 disables; 0100 fetch, 0101 read, 0110 write, 0111 read or write.
// - Linked data-plus-address setup applies the comparator 1 mask for range matching when comparator 1 selector is 0000.
// - Simultaneous start and stop triggers resolve to start only.
// - Trigger control register reports two comparators in a read-only field.
// - Comparator 1 match issues stop when action bit clear, start when set.
// - Comparator 0 match with action bit clear issues a stop trigger.
// - Comparator 0 flag asserts on address match when data-value matching is off.
// - With data matching on and link select clear, data match alone asserts.
// - With data matching and link select set, needs data and comparator 1 address.
// - Reserved comparator 1 function bits are read-only and return zero.
// - Link select holds only values zero or one, naming the linked comparator.
module wtt_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        bus_fetch_in,
  input  wire logic        bus_read_in,
  input  wire logic        bus_write_in,
  input  wire logic        comp0_addr_hit_in,
  input  wire logic        comp0_data_hit_in,
  input  wire logic        comp1_addr_hit_in,
  output logic             comp1_mask_apply_out,
  output logic             trace_start_trigger_out,
  output logic             trace_stop_trigger_out,
  output logic             irq_out
);

  // Whole state of the block.
  typedef struct packed {
    logic [3:0]  func0;
    logic        dvm0;
    logic [1:0]  dsz0;
    logic        lsel0;
    logic        flag0;
    logic [3:0]  func1;
    logic        flag1;
    logic        act0;
    logic        act1;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        mask_apply;
    logic        start;
    logic        stop;
    logic [31:0] rdata;
  } wtt_state_t;

  wtt_state_t  st_r;
  wtt_state_t  st_nxt;
  wtt_match_if mi ();

  logic        wr_fct0;
  logic        wr_fct1;
  logic        wr_tb;
  logic        wr_stat;
  logic        wr_mask;
  logic        rd_fct0;
  logic        rd_fct1;
  logic [1:0]  ev;
  logic        want_start;
  logic        want_stop;
  logic [31:0] rd_mux;

  // Address decode, used for every write and read strobe and in the checks.
  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Write strobes per register; read strobes only for the two function registers.
  assign wr_fct0 = reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_FCT0);
  assign wr_fct1 = reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_FCT1);
  assign wr_tb   = reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_TBCTRL);
  assign wr_stat = reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_IRQ_STAT);
  assign wr_mask = reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_IRQ_MASK);
  assign rd_fct0 = reg_rd_in && sel(reg_addr_in, wtt_pkg::OFF_FCT0);
  assign rd_fct1 = reg_rd_in && sel(reg_addr_in, wtt_pkg::OFF_FCT1);

  // Settings and observed accesses go to the matcher.
  assign mi.func0     = st_r.func0;
  assign mi.func1     = st_r.func1;
  assign mi.dvm0      = st_r.dvm0;
  assign mi.lsel0     = st_r.lsel0;
  assign mi.fetch     = bus_fetch_in;
  assign mi.rd        = bus_read_in;
  assign mi.wr        = bus_write_in;
  assign mi.addr0_hit = comp0_addr_hit_in;
  assign mi.data0_hit = comp0_data_hit_in;
  assign mi.addr1_hit = comp1_addr_hit_in;

  wtt_matcher u_matcher (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .mi      (mi.matcher)
  );

  // Match events of this cycle, comparator 0 in bit 0.
  assign ev = {mi.match1, mi.match0};

  // Trigger wishes from both comparators and their action bits.
  always_comb begin
    want_start = 1'b0;
    want_stop  = 1'b0;
    if (ev[1]) begin
      if (st_r.act1) begin
        want_start = 1'b1;
      end else begin
        want_stop = 1'b1;
      end
    end
    if (ev[0] && !st_r.act0) begin
      want_stop = 1'b1;
    end
    if (ev[0] && st_r.act0) begin
      want_start = 1'b1;
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_in)
      wtt_pkg::OFF_FCT0: begin
        rd_mux[wtt_pkg::FCT_FUNC_LSB +: 4]   = st_r.func0;
        rd_mux[wtt_pkg::FCT_DVM_BIT]         = st_r.dvm0;
        rd_mux[wtt_pkg::FCT_DSZ_LSB +: 2]    = st_r.dsz0;
        rd_mux[wtt_pkg::FCT_LSEL_BIT]        = st_r.lsel0;
        rd_mux[wtt_pkg::FCT_FLAG_BIT]        = st_r.flag0;
      end
      // only selector and flag are visible, all else zero.
      wtt_pkg::OFF_FCT1: begin
        rd_mux[wtt_pkg::FCT_FUNC_LSB +: 4]   = st_r.func1;
        rd_mux[wtt_pkg::FCT_FLAG_BIT]        = st_r.flag1;
      end
      wtt_pkg::OFF_TBCTRL: begin
        rd_mux[wtt_pkg::TB_NCMP_LSB +: 4]    = wtt_pkg::NUM_COMP;
        rd_mux[wtt_pkg::TB_ACT0_BIT]         = st_r.act0;
        rd_mux[wtt_pkg::TB_ACT1_BIT]         = st_r.act1;
      end
      wtt_pkg::OFF_IRQ_STAT: begin
        rd_mux[1:0] = st_r.irq_stat;
      end
      wtt_pkg::OFF_IRQ_MASK: begin
        rd_mux[1:0] = st_r.irq_mask;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Next-state logic for every register of the block.
  always_comb begin
    st_nxt = st_r;
    // Comparator 0 settings.
    if (wr_fct0) begin
      st_nxt.func0 = reg_wdata_in[wtt_pkg::FCT_FUNC_LSB +: 4];
      st_nxt.dvm0  = reg_wdata_in[wtt_pkg::FCT_DVM_BIT];
      st_nxt.dsz0  = reg_wdata_in[wtt_pkg::FCT_DSZ_LSB +: 2];
      // one bit keeps the select at zero or one.
      st_nxt.lsel0 = reg_wdata_in[wtt_pkg::FCT_LSEL_BIT];
    end
    // only the selector of comparator 1 is writable.
    if (wr_fct1) begin
      st_nxt.func1 = reg_wdata_in[wtt_pkg::FCT_FUNC_LSB +: 4];
    end
    if (wr_tb) begin
      st_nxt.act0 = reg_wdata_in[wtt_pkg::TB_ACT0_BIT];
      st_nxt.act1 = reg_wdata_in[wtt_pkg::TB_ACT1_BIT];
    end
    if (wr_mask) begin
      st_nxt.irq_mask = reg_wdata_in[1:0];
    end
    // Comparator 0 flag clears on read; a match in the same cycle wins.
    st_nxt.flag0 = ev[0] | (st_r.flag0 & ~rd_fct0);
    // sticky flag, clear on read, set wins.
    st_nxt.flag1 = ev[1] | (st_r.flag1 & ~rd_fct1);
    // Interrupt status is write-one-to-clear with set winning.
    st_nxt.irq_stat = ev | (st_r.irq_stat & ~(wr_stat ? reg_wdata_in[1:0] : 2'h0));
    // mask applied in linked data-plus-address setup while comparator 1 selector is 0000.
    st_nxt.mask_apply = st_r.dvm0 & st_r.lsel0 & (st_r.func1 == wtt_pkg::FUNC_OFF);
    st_nxt.start = want_start;
    st_nxt.stop  = want_stop & ~want_start;
    // Read data appear the cycle after the strobe and only then.
    st_nxt.rdata = reg_rd_in ? rd_mux : 32'h0000_0000;
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_r            <= '0;
      st_r.func0      <= wtt_pkg::RST_FUNC;
      st_r.func1      <= wtt_pkg::RST_FUNC;
      st_r.dsz0       <= wtt_pkg::RST_DSZ;
      st_r.irq_stat   <= wtt_pkg::RST_IRQ;
      st_r.irq_mask   <= wtt_pkg::RST_IRQ;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register, except the level interrupt.
  assign reg_rdata_out           = st_r.rdata;
  assign comp1_mask_apply_out    = st_r.mask_apply;
  assign trace_start_trigger_out = st_r.start;
  assign trace_stop_trigger_out  = st_r.stop;
  assign irq_out                 = |(st_r.irq_stat & st_r.irq_mask);

  // The trace buffer gates these triggers with its own enables.
  // far side gates triggers.

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_read_fct1;
    reg_rd_in && sel(reg_addr_in, wtt_pkg::OFF_FCT1);
  endsequence

  sequence s_read_tb;
    reg_rd_in && sel(reg_addr_in, wtt_pkg::OFF_TBCTRL);
  endsequence

  sequence s_read_fct0;
    reg_rd_in && sel(reg_addr_in, wtt_pkg::OFF_FCT0);
  endsequence

  sequence s_write_fct1;
    reg_wr_in && sel(reg_addr_in, wtt_pkg::OFF_FCT1);
  endsequence

  a_fct1_reserved_zero: assert property (s_read_fct1 |=> reg_rdata_out[23:4] == 20'h0_0000)
    else $error("Reserved bits of comparator 1 function register read nonzero.");

  a_fct1_data_bits: assert property (s_read_fct1 |=>
                                     reg_rdata_out[12:8] == 5'h00 && reg_rdata_out[31:25] == 7'h00)
    else $error("Data-value bits of comparator 1 read nonzero.");

  a_flag1_set_match: assert property (mi.match1 |=> st_r.flag1 ##1
                                      (reg_rdata_out[wtt_pkg::FCT_FLAG_BIT] || !$past(rd_fct1)))
    else $error("Comparator 1 flag did not set on match.");

  a_flag1_read_clear: assert property (s_read_fct1 ##0 !mi.match1 |=> !st_r.flag1)
    else $error("Comparator 1 flag not cleared by read.");

  a_flag1_set_wins: assert property (s_read_fct1 ##0 mi.match1 |=> st_r.flag1)
    else $error("Comparator 1 flag lost a match that came with a read.");

  a_flag1_no_spurious: assert property (!st_r.flag1 && !mi.match1 |=> !st_r.flag1)
    else $error("Comparator 1 flag set without a match.");

  a_flag1_write_keeps: assert property (s_write_fct1 ##0 st_r.flag1 |=> st_r.flag1)
    else $error("A write cleared the comparator 1 flag.");

  a_flag1_read_shows: assert property (s_read_fct1 ##0 st_r.flag1 |=> reg_rdata_out[wtt_pkg::FCT_FLAG_BIT])
    else $error("Read of comparator 1 did not show its set flag.");

  a_fetch_select: assert property (st_r.func1 == wtt_pkg::FUNC_FETCH && bus_fetch_in
                                   && comp1_addr_hit_in |-> mi.match1)
    else $error("Fetch selector missed a fetch.");

  a_fetch_only: assert property (st_r.func1 == wtt_pkg::FUNC_FETCH && !bus_fetch_in |-> !mi.match1)
    else $error("Fetch selector match_flag without a fetch.");

  a_read_not_write: assert property (st_r.func1 == wtt_pkg::FUNC_READ && !bus_read_in |-> !mi.match1)
    else $error("Read selector match_flag without a read.");

  a_rdwr_select: assert property (st_r.func1 == wtt_pkg::FUNC_RDWR && bus_write_in
                                  && comp1_addr_hit_in |-> mi.match1)
    else $error("Read-or-write selector missed a write.");

  a_mask_apply_off: assert property (!(st_r.dvm0 && st_r.lsel0) |=> !comp1_mask_apply_out)
    else $error("Comparator 1 mask applied outside the linked setup.");

  a_trig_start_wins: assert property (!(trace_start_trigger_out && trace_stop_trigger_out))
    else $error("Start and stop triggers raised together.");

  a_comp_count_two: assert property (s_read_tb |=> reg_rdata_out[31:28] == 4'h2)
    else $error("Comparator count does not read two.");

  a_cmp1_action_trig: assert property (mi.match1 |=> ($past(st_r.act1) ? trace_start_trigger_out
                                       : (trace_start_trigger_out || trace_stop_trigger_out)))
    else $error("Comparator 1 match gave the wrong trigger.");

  a_cmp1_stop_trig: assert property (mi.match1 && !st_r.act1 && !(mi.match0 && st_r.act0)
                                     |=> trace_stop_trigger_out)
    else $error("Comparator 1 match with action clear gave no stop.");

  a_no_trig_idle: assert property (!mi.match0 && !mi.match1
                                   |=> !trace_start_trigger_out && !trace_stop_trigger_out)
    else $error("Trigger raised without a match.");

  a_cmp0_stop_trig: assert property (mi.match0 && !st_r.act0 && !(mi.match1 && st_r.act1)
                                     |=> trace_stop_trigger_out)
    else $error("Comparator 0 match with action clear gave no stop.");

  a_addr_needs_hit: assert property (!st_r.dvm0 && !comp0_addr_hit_in |-> !mi.match0)
    else $error("Address-mode comparator 0 match_flag without an address hit.");

  a_linked_needs_data: assert property (st_r.dvm0 && st_r.lsel0 && !comp0_data_hit_in |-> !mi.match0)
    else $error("Linked comparator 0 match_flag without a data hit.");

  a_link_sel_width: assert property (s_read_fct0 |=> reg_rdata_out[15:13] == 3'h0)
    else $error("Bits above the link select read nonzero.");

  a_cmp0_start_trig: assert property (mi.match0 && st_r.act0
                                      |=> trace_start_trigger_out && !trace_stop_trigger_out)
    else $error("Comparator 0 match with action set gave no start.");

  a_link_mask_apply: assert property (st_r.dvm0 && st_r.lsel0 && st_r.func1 == 4'h0 |=> comp1_mask_apply_out)
    else $error("Linked setup did not apply comparator 1 mask.");
endmodule

/* wtt_pkg.sv */
// Purpose: Shared constants and decode helper for the watchpoint trace trigger block.
// Assumes: One 200 MHz system clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on an 8-bit register port.
package wtt_pkg;

  // Register port geometry.
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;

  // Register offsets.
  localparam logic [7:0]  OFF_FCT0     = 8'h00;
  localparam logic [7:0]  OFF_FCT1     = 8'h04;
  localparam logic [7:0]  OFF_TBCTRL   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h10;

  // Field positions of the comparator function registers.
  localparam int          FCT_FUNC_LSB = 0;
  localparam int          FCT_DVM_BIT  = 8;
  localparam int          FCT_DSZ_LSB  = 10;
  localparam int          FCT_LSEL_BIT = 12;
  localparam int          FCT_FLAG_BIT = 24;

  // Field positions of the trace trigger control register.
  localparam int          TB_ACT0_BIT  = 0;
  localparam int          TB_ACT1_BIT  = 1;
  localparam int          TB_NCMP_LSB  = 28;
  localparam logic [3:0]  NUM_COMP     = 4'h2;

  // Interrupt status bit positions.
  localparam int          IRQ_CMP0_BIT = 0;
  localparam int          IRQ_CMP1_BIT = 1;

  // Function selector encodings.
  localparam logic [3:0]  FUNC_OFF     = 4'h0;
  localparam logic [3:0]  FUNC_FETCH   = 4'h4;
  localparam logic [3:0]  FUNC_READ    = 4'h5;
  localparam logic [3:0]  FUNC_WRITE   = 4'h6;
  localparam logic [3:0]  FUNC_RDWR    = 4'h7;

  // Values after reset.
  localparam logic [3:0]  RST_FUNC     = 4'h0;
  localparam logic [1:0]  RST_DSZ      = 2'h0;
  localparam logic [1:0]  RST_IRQ      = 2'h0;

  // Decides whether an observed access is the kind that a selector asks for.
  function automatic logic func_hit(input logic [3:0] func, input logic fetch, input logic rd,
                                    input logic wr);
    logic hit;
    hit = 1'b0;
    case (func)
      FUNC_FETCH: hit = fetch;
      FUNC_READ:  hit = rd;
      FUNC_WRITE: hit = wr;
      FUNC_RDWR:  hit = rd | wr;
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

/* wtt_match_if.sv */
// Purpose: Carries comparator settings, observed accesses and qualified matches.
// Assumes: All signals are on the system clock.
// Notes:   The top drives settings and accesses; the matcher drives the matches.
`timescale 1ns/1ps
interface wtt_match_if;
  logic [3:0] func0;
  logic [3:0] func1;
  logic       dvm0;
  logic       lsel0;
  logic       fetch;
  logic       rd;
  logic       wr;
  logic       addr0_hit;
  logic       data0_hit;
  logic       addr1_hit;
  logic       match0;
  logic       match1;

  modport top (output func0, func1, dvm0, lsel0, fetch, rd, wr, addr0_hit, data0_hit, addr1_hit,
               input match0, match1);
  modport matcher (input func0, func1, dvm0, lsel0, fetch, rd, wr, addr0_hit, data0_hit, addr1_hit,
                   output match0, match1);
endinterface

/* wtt_matcher.sv */
// Purpose: Qualifies raw comparator hits by function selector and data-value mode.
// Assumes: Raw hits and access kinds are same-clock pulses from the bus observer.
// Notes:   Purely combinational; the clock and reset only serve the checks.
`timescale 1ns/1ps
module wtt_matcher (
  input  wire logic   mclk_in,
  input  wire logic   rst_in,
  wtt_match_if.matcher mi
);

  logic [3:0] func_a [2];
  logic [1:0] op_hit;

  // Selector of each comparator, gathered for the loop.
  assign func_a[0] = mi.func0;
  assign func_a[1] = mi.func1;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_op
      assign op_hit[g] = wtt_pkg::func_hit(func_a[g], mi.fetch, mi.rd, mi.wr);
    end
  endgenerate

  // Comparator 0 match by mode: address, data alone, or data linked to comparator 1 address.
  always_comb begin
    if (!mi.dvm0) begin
      mi.match0 = op_hit[0] & mi.addr0_hit;
    end else if (!mi.lsel0) begin
      mi.match0 = op_hit[0] & mi.data0_hit;
    end else begin
      mi.match0 = op_hit[0] & mi.data0_hit & mi.addr1_hit;
    end
  end

  // Comparator 1 compares addresses only.
  assign mi.match1 = op_hit[1] & mi.addr1_hit;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_addr_mode_match: assert property (!mi.dvm0 |-> mi.match0 == (op_hit[0] && mi.addr0_hit))
    else $error("Address-mode match of comparator 0 is wrong.");
  a_data_mode_match: assert property (mi.dvm0 && !mi.lsel0 |-> mi.match0 == (op_hit[0] && mi.data0_hit))
    else $error("Data-mode match of comparator 0 is wrong.");
  a_linked_mode_match: assert property (mi.dvm0 && mi.lsel0 && !mi.addr1_hit |-> !mi.match0)
    else $error("Linked match fired without comparator 1 address hit.");
  a_disabled_no_match: assert property (mi.func1 == wtt_pkg::FUNC_OFF |-> !mi.match1)
    else $error("Disabled comparator 1 produced a match.");
endmodule

/* wtt_trace_rec.sv */
// Purpose: Behavioural model of the trace buffer recording control beside the trigger block.
// Assumes: Triggers are one-cycle pulses on the same clock as the block.
// Notes:   The enables are driven by the bench so that gating can be checked.
`timescale 1ns/1ps
module wtt_trace_rec (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  input  wire logic stop_in,
  input  wire logic start_en_in,
  input  wire logic stop_en_in,
  output logic      recording_out
);
  typedef struct packed {
    logic recording;
  } wtt_rec_state_t;

  wtt_rec_state_t state_r;
  wtt_rec_state_t state_nxt;

  // Works out the next recording state from the trigger pulses.
  always_comb begin
    state_nxt = state_r;
    if (start_in && start_en_in) begin
      state_nxt.recording = 1'b1;
    end else if (stop_in && stop_en_in) begin
      state_nxt.recording = 1'b0;
    end
  end

  // Holds the recording state; reset leaves the buffer idle.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign recording_out = state_r.recording;
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the watchpoint trace trigger block.
// Assumes: Register reads answer one cycle after the strobe; triggers one cycle after a match.
// Notes:   Ordinary match cases run from a table; registers and interrupts are tested by hand.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [3:0] f0;
    logic [1:0] dl;
    logic [3:0] f1;
    logic [1:0] act;
    logic [2:0] kind;
    logic [2:0] hit;
    logic [1:0] exp;
  } wtt_row_t;

  logic        mclk  = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        fetch = 1'b0;
  logic        brd   = 1'b0;
  logic        bwr   = 1'b0;
  logic        a0    = 1'b0;
  logic        d0    = 1'b0;
  logic        a1    = 1'b0;
  logic        sen   = 1'b1;
  logic        pen   = 1'b0;
  logic [31:0] rdata;
  logic        mapply;
  logic        trace_start_trigger;
  logic        trace_stop_trigger;
  logic        irq;
  logic        rec;
  int          n_mismatch  = 0;
  int          check_count = 0;

  // Rows: f0, {dvm, lsel}, f1, actions, {fetch, read, write}, {a0, d0, a1}, {start, stop}.
  // rows use only the five defined selector encodings.
  wtt_row_t rows [17] = '{
    '{4'h0, 2'h0, 4'h0, 2'h2, 3'h2, 3'h1, 2'h0}, '{4'h0, 2'h0, 4'h4, 2'h2, 3'h4, 3'h1, 2'h2},
    '{4'h0, 2'h0, 4'h5, 2'h0, 3'h2, 3'h1, 2'h1}, '{4'h0, 2'h0, 4'h6, 2'h2, 3'h1, 3'h1, 2'h2},
    '{4'h0, 2'h0, 4'h7, 2'h2, 3'h2, 3'h1, 2'h2}, '{4'h0, 2'h0, 4'h7, 2'h0, 3'h1, 3'h1, 2'h1},
    '{4'h0, 2'h0, 4'h6, 2'h2, 3'h2, 3'h1, 2'h0}, '{4'h0, 2'h0, 4'h4, 2'h2, 3'h2, 3'h1, 2'h0},
    '{4'h5, 2'h0, 4'h0, 2'h0, 3'h2, 3'h4, 2'h1}, '{4'h5, 2'h0, 4'h0, 2'h1, 3'h2, 3'h4, 2'h2},
    '{4'h5, 2'h0, 4'h0, 2'h1, 3'h2, 3'h2, 2'h0}, '{4'h5, 2'h2, 4'h0, 2'h1, 3'h2, 3'h2, 2'h2},
    '{4'h5, 2'h2, 4'h0, 2'h1, 3'h2, 3'h4, 2'h0}, '{4'h6, 2'h3, 4'h0, 2'h1, 3'h1, 3'h2, 2'h0},
    '{4'h6, 2'h3, 4'h0, 2'h1, 3'h1, 3'h3, 2'h2}, '{4'h5, 2'h0, 4'h5, 2'h2, 3'h2, 3'h5, 2'h2},
    '{4'h5, 2'h0, 4'h5, 2'h0, 3'h2, 3'h5, 2'h1}};

  // Clock at 200 MHz.
  always #2.5 mclk = ~mclk;

  wtt_top dut (.mclk_in(mclk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .bus_fetch_in(fetch),
    .bus_read_in(brd), .bus_write_in(bwr), .comp0_addr_hit_in(a0), .comp0_data_hit_in(d0),
    .comp1_addr_hit_in(a1), .comp1_mask_apply_out(mapply), .trace_start_trigger_out(trace_start_trigger),
    .trace_stop_trigger_out(trace_stop_trigger), .irq_out(irq));

  wtt_trace_rec rec_model (.mclk_in(mclk), .rst_in(rst), .start_in(trace_start_trigger), .stop_in(trace_stop_trigger),
    .start_en_in(sen), .stop_en_in(pen), .recording_out(rec));

  // Compares a register word.
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compares a single output bit.
  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // One-cycle register read; data are looked at in the single cycle they stand.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string name);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 chk_word(name, e, rdata);
  endtask

  // One observed bus access with raw hits; returns while the triggers stand.
  task automatic access(input logic [2:0] k, input logic [2:0] h);
    @(posedge mclk);
    {fetch, brd, bwr} <= k;
    {a0, d0, a1}      <= h;
    @(posedge mclk);
    {fetch, brd, bwr} <= 3'h0;
    {a0, d0, a1}      <= 3'h0;
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 chk_bit("irq", 1'b0, irq);
    chk_bit("start", 1'b0, trace_start_trigger);
    reg_rd(8'h04, 32'h0000_0000, "fct1");
    reg_rd(8'h08, 32'h2000_0000, "tbctrl");
    reg_rd(8'h10, 32'h0000_0000, "mask");
    $display("Test reset done");
    foreach (rows[i]) begin
      reg_wr(8'h00, {19'h0, rows[i].dl[0], 3'h0, rows[i].dl[1], 4'h0, rows[i].f0});
      reg_wr(8'h04, {28'h0, rows[i].f1});
      reg_wr(8'h08, {30'h0, rows[i].act});
      access(rows[i].kind, rows[i].hit);
      chk_bit("start", rows[i].exp[1], trace_start_trigger);
      chk_bit("stop", rows[i].exp[0], trace_stop_trigger);
    end
    $display("Test match table done");
    reg_rd(8'h04, 32'h0100_0005, "fct1 flag");
    reg_rd(8'h04, 32'h0000_0005, "fct1 cleared");
    reg_wr(8'h04, 32'hFFFF_FFF6);
    reg_rd(8'h04, 32'h0000_0006, "fct1 zero bits");
    reg_wr(8'h08, 32'hFFFF_FFFF);
    reg_rd(8'h08, 32'h2000_0003, "tbctrl count");
    reg_wr(8'h14, 32'hFFFF_FFFF);
    reg_rd(8'h14, 32'h0000_0000, "unmapped");
    $display("Test register bits done");
    reg_rd(8'h0C, 32'h0000_0003, "status");
    chk_bit("irq masked", 1'b0, irq);
    reg_wr(8'h10, 32'h0000_0002);
    #1 chk_bit("irq", 1'b1, irq);
    reg_wr(8'h0C, 32'h0000_0002);
    #1 chk_bit("irq cleared", 1'b0, irq);
    reg_rd(8'h0C, 32'h0000_0001, "status w1c");
    access(3'h1, 3'h1);
    chk_bit("start", 1'b1, trace_start_trigger);
    chk_bit("irq again", 1'b1, irq);
    reg_wr(8'h0C, 32'h0000_0003);
    reg_wr(8'h10, 32'h0000_0000);
    $display("Test interrupt done");
    reg_wr(8'h00, 32'h0000_1105);
    reg_wr(8'h04, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    #1 chk_bit("mask apply", 1'b1, mapply);
    reg_wr(8'h00, 32'h0000_0005);
    repeat (2) @(posedge mclk);
    #1 chk_bit("mask apply off", 1'b0, mapply);
    $display("Test linked range done");
    reg_wr(8'h04, 32'h0000_0005);
    reg_wr(8'h08, 32'h0000_0001);
    access(3'h2, 3'h1);
    chk_bit("stop", 1'b1, trace_stop_trigger);
    @(posedge mclk);
    #1 chk_bit("stop gated", 1'b1, rec);
    pen <= 1'b1;
    access(3'h2, 3'h1);
    @(posedge mclk);
    #1 chk_bit("stopped", 1'b0, rec);
    access(3'h2, 3'h5);
    chk_bit("stop both", 1'b0, trace_stop_trigger);
    chk_bit("start both", 1'b1, trace_start_trigger);
    @(posedge mclk);
    #1 chk_bit("recording", 1'b1, rec);
    $display("Test recording done");
    reg_wr(8'h10, 32'h0000_0003);
    #1 chk_bit("irq before reset", 1'b1, irq);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    reg_rd(8'h00, 32'h0000_0000, "fct0 after reset");
    chk_bit("irq after reset", 1'b0, irq);
    reg_rd(8'h08, 32'h2000_0000, "tbctrl after reset");
    $display("Test second reset done");
    results();
  end
endmodule
